/* src/lba_arbiter.sv */
// Level-2 RAM bandwidth arbiter with its APB register file.
// Assumes requesters hold a request level until they see their grant pulse,
// then drop it in the following cycle; all inputs share CORE_CLK_IN.
//
// Functional notes
// - One grant at a time shares level-2 bandwidth between core and non-core requests.
// - Every non-core request, from the internal DMA engine or the slave port, is DMA class.
// - Grants follow each class's programmed priority, the lower value being more urgent.
// - Each requester counts the cycles its pending request is held off by higher priority.
// - A requester whose count reaches the starvation threshold wins a slice regardless.
// - An equal-priority tie between core and DMA goes to the core unless a requester is starved.
// - Back-to-back core requests at equal priority cannot hold off DMA: the core sits out the cycle after each grant.
// - The arbiter's own command traffic requests at priority level 7.
// - Equal priorities among the DMA requesters share fairly without penalty.
// - The core priority comes from the core arbitration priority register.
// - The DMA engine priority is a shifted field of its count register beside the size.
// - Slave-port requests take the priority field of their originating bus master.
//
// Implementation choice: the APB interface to the registers.
module lba_arbiter (
    input  wire logic                         CORE_CLK_IN,     // Core clock, 125 MHz.
    input  wire logic                         RESET_IN,        // Asynchronous reset, high.
    input  wire logic                         PSEL_IN,         // APB select.
    input  wire logic                         PENABLE_IN,      // APB access phase.
    input  wire logic                         PWRITE_IN,       // APB write.
    input  wire logic [31:0]                  PADDR_IN,        // APB byte address.
    input  wire logic [31:0]                  PWDATA_IN,       // APB write data.
    input  wire logic [3:0]                   PSTRB_IN,        // APB byte strobes.
    output logic      [31:0]                  PRDATA_OUT,      // APB read data.
    output logic                              PREADY_OUT,      // APB ready.
    output logic                              PSLVERR_OUT,     // APB unmapped address.
    input  wire logic                         CORE_REQ_IN,     // Core request level.
    input  wire logic                         INTERNAL_DMA_ENGINE_REQ_IN,     // DMA engine request level.
    input  wire logic                         SLAVE_DMA_PORT_REQ_IN,     // Slave-port request level.
    input  wire logic [lba_pkg::MST_ID_W-1:0] SLAVE_DMA_PORT_MASTER_IN,  // Slave-port master id.
    input  wire logic                         CMD_REQ_IN,      // Command logic request.
    output logic                              CORE_GRANT_OUT,  // Core grant pulse.
    output logic                              INTERNAL_DMA_ENGINE_GRANT_OUT,  // DMA engine grant pulse.
    output logic                              SLAVE_DMA_PORT_GRANT_OUT,  // Slave-port grant pulse.
    output logic                              CMD_GRANT_OUT,   // Command grant pulse.
    output logic      [31:0]                  DMA_SRC_OUT,     // DMA engine source.
    output logic      [31:0]                  DMA_DST_OUT,     // DMA engine destination.
    output logic      [lba_pkg::BUF_SIZE_W-1:0] DMA_SIZE_OUT   // DMA engine buffer size.
);
    localparam int unsigned PW = lba_pkg::PRI_W;
    localparam int unsigned NR = lba_pkg::NREQ;

    // Register file values.
    logic [31:0] src_q;
    logic [31:0] dst_q;
    logic [31:0] cnt_q;
    logic [31:0] core_q;
    logic [31:0] thr_q;
    logic [31:0] mst1_q;
    logic [31:0] mst2_q;

    // APB handshake state.
    logic        setup_w;
    logic        access_w;
    logic        wr_en_w;
    logic        hit_src_w;
    logic        hit_dst_w;
    logic        hit_cnt_w;
    logic        hit_core_w;
    logic        hit_thr_w;
    logic        hit_stat_w;
    logic        hit_mst1_w;
    logic        hit_mst2_w;
    logic        hit_any_w;
    logic [31:0] rd_mux_w;
    logic [31:0] status_w;
    logic [31:0] rdata_r;
    logic        ready_r;
    logic        slverr_r;

    // Arbitration state.
    logic [NR-1:0]    req_w;
    logic [NR-1:0]    elig_w;
    logic [NR-1:0]    starved_w;
    logic [NR-1:0]    blocked_w;
    logic [NR-1:0]    win_w;
    logic [NR-1:0]    grant_r;
    logic [NR-1:0]    last_grant_r;
    logic [PW-1:0]    pri_w [NR];
    logic [PW-1:0]    best_pri_w;
    logic [PW-1:0]    win_pri_w;
    logic             any_elig_w;
    logic             any_starved_w;
    logic [31:0]      mst_word_w;
    logic [4:0]       mst_bit_w;
    logic [1:0]       rr_r;
    logic [1:0]       rr_nxt;

    // APB phase decode; the slave answers with no wait states.
    assign setup_w  = PSEL_IN && !PENABLE_IN;
    assign access_w = PSEL_IN && PENABLE_IN && ready_r;
    assign wr_en_w  = access_w && PWRITE_IN && !slverr_r;

    // Address decode for every mapped word.
    assign hit_src_w  = (PADDR_IN == lba_pkg::ADDR_DMA_SRC);
    assign hit_dst_w  = (PADDR_IN == lba_pkg::ADDR_DMA_DST);
    assign hit_cnt_w  = (PADDR_IN == lba_pkg::ADDR_DMA_CNT);
    assign hit_core_w = (PADDR_IN == lba_pkg::ADDR_CORE_PRI);
    assign hit_thr_w  = (PADDR_IN == lba_pkg::ADDR_THRESHOLD);
    assign hit_stat_w = (PADDR_IN == lba_pkg::ADDR_STATUS);
    assign hit_mst1_w = (PADDR_IN == lba_pkg::ADDR_MST_PRI1);
    assign hit_mst2_w = (PADDR_IN == lba_pkg::ADDR_MST_PRI2);
    assign hit_any_w  = hit_src_w | hit_dst_w | hit_cnt_w | hit_core_w
                      | hit_thr_w | hit_stat_w | hit_mst1_w | hit_mst2_w;

    // Software-visible arbiter state: pending, starved and last grant.
    assign status_w = (32'(req_w) << lba_pkg::ST_PEND_LSB)
                    | (32'(starved_w) << lba_pkg::ST_STARV_LSB)
                    | (32'(last_grant_r) << lba_pkg::ST_GRANT_LSB);

    // Read data selection; unmapped words read as zero.
    assign rd_mux_w = hit_src_w  ? src_q  :
                      hit_dst_w  ? dst_q  :
                      hit_cnt_w  ? cnt_q  :
                      hit_core_w ? core_q :
                      hit_thr_w  ? thr_q  :
                      hit_stat_w ? status_w :
                      hit_mst1_w ? mst1_q :
                      hit_mst2_w ? mst2_q : lba_pkg::RST_ZERO;

    // Capture the answer in the setup cycle so it stands for the access cycle.
    always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            ready_r  <= 1'b0;
            slverr_r <= 1'b0;
            rdata_r  <= lba_pkg::RST_ZERO;
        end else begin
            ready_r  <= setup_w;
            slverr_r <= setup_w && !hit_any_w;
            if (setup_w && !PWRITE_IN) begin
                rdata_r <= rd_mux_w;
            end
        end
    end

    assign PREADY_OUT  = ready_r;
    assign PSLVERR_OUT = slverr_r;
    assign PRDATA_OUT  = rdata_r;

    lba_reg32 #(.RESET_VAL(lba_pkg::RST_ZERO)) u_src (
        .clk_in   (CORE_CLK_IN),
        .rst_in   (RESET_IN),
        .we_in    (wr_en_w && hit_src_w),
        .strb_in  (PSTRB_IN),
        .wdata_in (PWDATA_IN),
        .q_out    (src_q)
    );

    lba_reg32 #(.RESET_VAL(lba_pkg::RST_ZERO)) u_dst (
        .clk_in   (CORE_CLK_IN),
        .rst_in   (RESET_IN),
        .we_in    (wr_en_w && hit_dst_w),
        .strb_in  (PSTRB_IN),
        .wdata_in (PWDATA_IN),
        .q_out    (dst_q)
    );

    lba_reg32 #(.RESET_VAL(lba_pkg::RST_DMA_CNT)) u_cnt (
        .clk_in   (CORE_CLK_IN),
        .rst_in   (RESET_IN),
        .we_in    (wr_en_w && hit_cnt_w),
        .strb_in  (PSTRB_IN),
        .wdata_in (PWDATA_IN),
        .q_out    (cnt_q)
    );

    lba_reg32 #(.RESET_VAL(lba_pkg::RST_CORE_PRI)) u_core (
        .clk_in   (CORE_CLK_IN),
        .rst_in   (RESET_IN),
        .we_in    (wr_en_w && hit_core_w),
        .strb_in  (PSTRB_IN),
        .wdata_in (PWDATA_IN),
        .q_out    (core_q)
    );

    lba_reg32 #(.RESET_VAL(lba_pkg::RST_THRESHOLD)) u_thr (
        .clk_in   (CORE_CLK_IN),
        .rst_in   (RESET_IN),
        .we_in    (wr_en_w && hit_thr_w),
        .strb_in  (PSTRB_IN),
        .wdata_in (PWDATA_IN),
        .q_out    (thr_q)
    );

    lba_reg32 #(.RESET_VAL(lba_pkg::RST_MST_PRI)) u_mst1 (
        .clk_in   (CORE_CLK_IN),
        .rst_in   (RESET_IN),
        .we_in    (wr_en_w && hit_mst1_w),
        .strb_in  (PSTRB_IN),
        .wdata_in (PWDATA_IN),
        .q_out    (mst1_q)
    );

    lba_reg32 #(.RESET_VAL(lba_pkg::RST_MST_PRI)) u_mst2 (
        .clk_in   (CORE_CLK_IN),
        .rst_in   (RESET_IN),
        .we_in    (wr_en_w && hit_mst2_w),
        .strb_in  (PSTRB_IN),
        .wdata_in (PWDATA_IN),
        .q_out    (mst2_q)
    );

    // The DMA engine transfer setup leaves the block as plain register values.
    assign DMA_SRC_OUT  = src_q;
    assign DMA_DST_OUT  = dst_q;
    assign DMA_SIZE_OUT = cnt_q[lba_pkg::BUF_SIZE_W-1:0];

    assign req_w[lba_pkg::REQ_CORE] = CORE_REQ_IN;
    assign req_w[lba_pkg::REQ_INTERNAL_DMA_ENGINE] = INTERNAL_DMA_ENGINE_REQ_IN;
    assign req_w[lba_pkg::REQ_SLAVE_DMA_PORT] = SLAVE_DMA_PORT_REQ_IN;
    assign req_w[lba_pkg::REQ_CMD]  = CMD_REQ_IN;

    // skip a requester still seeing its grant.
    assign elig_w = req_w & ~grant_r;

    assign mst_word_w = SLAVE_DMA_PORT_MASTER_IN[lba_pkg::MST_ID_W-1] ? mst2_q : mst1_q;
    assign mst_bit_w  = 5'(SLAVE_DMA_PORT_MASTER_IN[lba_pkg::MST_ID_W-2:0]) << lba_pkg::MST_NIB_SHIFT;

    assign pri_w[lba_pkg::REQ_CORE] = core_q[lba_pkg::CORE_PRI_LSB +: PW];
    assign pri_w[lba_pkg::REQ_INTERNAL_DMA_ENGINE] = cnt_q[lba_pkg::DMA_PRI_LSB +: PW];
    assign pri_w[lba_pkg::REQ_SLAVE_DMA_PORT] = mst_word_w[mst_bit_w +: PW];
    assign pri_w[lba_pkg::REQ_CMD]  = lba_pkg::CMD_PRI;

    always_comb begin
        best_pri_w    = '1;
        any_elig_w    = 1'b0;
        any_starved_w = 1'b0;
        for (int i = 0; i < NR; i++) begin
            if (elig_w[i]) begin
                any_elig_w = 1'b1;
                if (pri_w[i] < best_pri_w) begin
                    best_pri_w = pri_w[i];
                end
            end
            if (elig_w[i] && starved_w[i]) begin
                any_starved_w = 1'b1;
            end
        end
    end

    // Choose one winner: a starved requester first, else the most urgent level.
    always_comb begin
        logic [1:0] k;
        logic       done;
        k    = '0;
        done = 1'b0;
        win_w = '0;
        if (any_starved_w) begin
            for (int n = 0; n < NR; n++) begin
                k = 2'(rr_r + 2'(n));
                if (!done && elig_w[k] && starved_w[k]) begin
                    win_w[k] = 1'b1;
                    done     = 1'b1;
                end
            end
        end else if (elig_w[lba_pkg::REQ_CORE]
                     && (pri_w[lba_pkg::REQ_CORE] == best_pri_w)) begin
            win_w[lba_pkg::REQ_CORE] = 1'b1;
        end else begin
            for (int n = 0; n < NR; n++) begin
                k = 2'(rr_r + 2'(n));
                if (!done && (k != lba_pkg::REQ_CORE) && elig_w[k]
                    && (pri_w[k] == best_pri_w)) begin
                    win_w[k] = 1'b1;
                    done     = 1'b1;
                end
            end
        end
    end

    // Level of the chosen winner, used to judge who was held off.
    always_comb begin
        win_pri_w = '1;
        for (int i = 0; i < NR; i++) begin
            if (win_w[i]) begin
                win_pri_w = pri_w[i];
            end
        end
    end

    assign blocked_w = elig_w & ~win_w
                     & {NR{any_elig_w}}
                     & {(pri_w[3] > win_pri_w), (pri_w[2] > win_pri_w),
                        (pri_w[1] > win_pri_w), (pri_w[0] > win_pri_w)};

    // Next rotation start sits just after a granted non-core requester (DMA engine, slave port or command).
    always_comb begin
        rr_nxt = rr_r;
        for (int i = 1; i < NR; i++) begin
            if (win_w[i]) begin
                rr_nxt = 2'(i + 1);
            end
        end
    end

    generate
        for (genvar g = 0; g < NR; g++) begin : g_wait
            lba_wait_cnt u_cnt (
                .clk_in      (CORE_CLK_IN),
                .rst_in      (RESET_IN),
                .clear_in    (win_w[g]),
                .block_in    (blocked_w[g]),
                .thresh_in   (thr_q[lba_pkg::THRESH_LSB +: lba_pkg::CNT_W]),
                .starved_out (starved_w[g])
            );
        end
    endgenerate

    always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            grant_r      <= '0;
            last_grant_r <= '0;
            rr_r         <= lba_pkg::REQ_INTERNAL_DMA_ENGINE;
        end else begin
            grant_r <= win_w;
            rr_r    <= rr_nxt;
            if (win_w != '0) begin
                last_grant_r <= win_w;
            end
        end
    end

    // Grant pulses leave straight from the grant flip-flops.
    assign CORE_GRANT_OUT = grant_r[lba_pkg::REQ_CORE];
    assign INTERNAL_DMA_ENGINE_GRANT_OUT = grant_r[lba_pkg::REQ_INTERNAL_DMA_ENGINE];
    assign SLAVE_DMA_PORT_GRANT_OUT = grant_r[lba_pkg::REQ_SLAVE_DMA_PORT];
    assign CMD_GRANT_OUT  = grant_r[lba_pkg::REQ_CMD];
endmodule : lba_arbiter

/* src/lba_pkg.sv */
// Constants shared by the level-2 bandwidth arbiter and its helper modules.
// Assumes one 125 MHz clock and an APB register port with 32-bit data.
package lba_pkg;
    // Bus and field widths.
    localparam int unsigned DATA_W     = 32;
    localparam int unsigned PRI_W      = 3;
    localparam int unsigned NREQ       = 4;
    localparam int unsigned CNT_W      = 8;
    localparam int unsigned BUF_SIZE_W = 16;
    localparam int unsigned MST_ID_W   = 4;
    // Register byte addresses.
    localparam logic [31:0] ADDR_DMA_SRC   = 32'h0182_0108;
    localparam logic [31:0] ADDR_DMA_DST   = 32'h0182_010C;
    localparam logic [31:0] ADDR_DMA_CNT   = 32'h0182_0110;
    localparam logic [31:0] ADDR_CORE_PRI  = 32'h0184_1000;
    localparam logic [31:0] ADDR_THRESHOLD = 32'h0184_1004;
    localparam logic [31:0] ADDR_STATUS    = 32'h0184_1008;
    localparam logic [31:0] ADDR_MST_PRI1  = 32'h01C1_4114;
    localparam logic [31:0] ADDR_MST_PRI2  = 32'h01C1_4118;
    // Field positions.
    localparam int unsigned DMA_PRI_LSB   = 29;
    localparam int unsigned CORE_PRI_LSB  = 0;
    localparam int unsigned THRESH_LSB    = 0;
    localparam int unsigned MST_NIB_SHIFT = 2;
    localparam int unsigned ST_PEND_LSB   = 0;
    localparam int unsigned ST_STARV_LSB  = 4;
    localparam int unsigned ST_GRANT_LSB  = 8;
    // Reset values.
    localparam logic [31:0] RST_ZERO      = 32'h0000_0000;
    localparam logic [31:0] RST_CORE_PRI  = 32'h0000_0001;
    localparam logic [31:0] RST_DMA_CNT   = 32'h8000_0000;
    localparam logic [31:0] RST_MST_PRI   = 32'h4444_4444;
    localparam logic [31:0] RST_THRESHOLD = 32'h0000_0010;
    // Priority level used by the arbiter's own command traffic.
    localparam logic [PRI_W-1:0] CMD_PRI = 3'h7;
    // Requester indices.
    localparam logic [1:0] REQ_CORE = 2'h0;
    localparam logic [1:0] REQ_INTERNAL_DMA_ENGINE = 2'h1;
    localparam logic [1:0] REQ_SLAVE_DMA_PORT = 2'h2;
    localparam logic [1:0] REQ_CMD  = 2'h3;
endpackage : lba_pkg

/* src/lba_reg32.sv */
// One software-writable 32-bit register with APB byte strobes.
// Assumes the caller decodes the address and qualifies the write strobe.
module lba_reg32 #(
    parameter logic [31:0] RESET_VAL = 32'h0000_0000
) (
    input  wire logic        clk_in,    // Core clock.
    input  wire logic        rst_in,    // Asynchronous reset, active high.
    input  wire logic        we_in,     // Write this cycle.
    input  wire logic [3:0]  strb_in,   // Byte lanes to write.
    input  wire logic [31:0] wdata_in,  // Write data.
    output logic      [31:0] q_out      // Stored value.
);
    logic [31:0] val_r;
    logic [31:0] val_nxt;

    // Merge the enabled byte lanes into the held value.
    always_comb begin
        val_nxt = val_r;
        for (int b = 0; b < 4; b++) begin
            if (we_in && strb_in[b]) begin
                val_nxt[b*8 +: 8] = wdata_in[b*8 +: 8];
            end
        end
    end

    // Hold the register.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            val_r <= RESET_VAL;
        end else begin
            val_r <= val_nxt;
        end
    end

    assign q_out = val_r;
endmodule : lba_reg32

/* src/lba_wait_cnt.sv */
// Contention counter for one requester, saturating at its threshold.
// Assumes the caller states each cycle whether the request was held off.
module lba_wait_cnt (
    input  wire logic                      clk_in,     // Core clock.
    input  wire logic                      rst_in,     // Asynchronous reset, active high.
    input  wire logic                      clear_in,   // Requester granted this cycle.
    input  wire logic                      block_in,   // Held off by higher priority.
    input  wire logic [lba_pkg::CNT_W-1:0] thresh_in,  // Starvation threshold, zero is off.
    output logic                           starved_out // Count has reached the threshold.
);
    logic [lba_pkg::CNT_W-1:0] cnt_r;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            cnt_r <= '0;
        end else if (clear_in) begin
            cnt_r <= '0;
        end else if (block_in && (cnt_r < thresh_in)) begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    assign starved_out = (thresh_in != '0) && (cnt_r >= thresh_in);
endmodule : lba_wait_cnt

/* verif/lba_req_model.sv */
// Behavioural requester standing outside the arbiter, one per requester class.
// Assumes go and hold are driven just after the rising edge of the shared clock.
module lba_req_model (
    input  wire logic clk_in,   // Core clock.
    input  wire logic rst_in,   // Reset, active high.
    input  wire logic go_in,    // Raise one request.
    input  wire logic hold_in,  // Keep requesting after each grant.
    input  wire logic grant_in, // Grant pulse from the arbiter.
    output logic      req_out   // Request level.
);
    timeunit 1ns;
    timeprecision 1ps;
    // hold until granted
    // The level stays up until a grant is seen, so no request is ever withdrawn early.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            req_out <= 1'b0;
        end else if (go_in || hold_in) begin
            req_out <= 1'b1;
        end else if (grant_in) begin
            req_out <= 1'b0;
        end
    end
endmodule : lba_req_model

/* verif/lba_arbiter_chk.sv */
// Port-level assertions for the bandwidth arbiter.
// Assumes it is bound to the arbiter's top module and sees its ports only.
module lba_arbiter_chk (
    input wire logic        CORE_CLK_IN,    // Core clock.
    input wire logic        RESET_IN,       // Reset, active high.
    input wire logic        PSEL_IN,        // APB select.
    input wire logic        PENABLE_IN,     // APB access phase.
    input wire logic        PWRITE_IN,      // APB write.
    input wire logic [31:0] PADDR_IN,       // APB address.
    input wire logic        PREADY_OUT,     // APB ready.
    input wire logic        PSLVERR_OUT,    // APB error.
    input wire logic        CORE_REQ_IN,    // Core request.
    input wire logic        INTERNAL_DMA_ENGINE_REQ_IN,    // Engine request.
    input wire logic        SLAVE_DMA_PORT_REQ_IN,    // Port request.
    input wire logic        CMD_REQ_IN,     // Command request.
    input wire logic        CORE_GRANT_OUT, // Core grant.
    input wire logic        INTERNAL_DMA_ENGINE_GRANT_OUT, // Engine grant.
    input wire logic        SLAVE_DMA_PORT_GRANT_OUT, // Port grant.
    input wire logic        CMD_GRANT_OUT,  // Command grant.
    input wire logic [31:0] DMA_SRC_OUT     // Engine source.
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge CORE_CLK_IN);
    endclocking
    default disable iff (RESET_IN);
    // Requests and grants gathered in core, engine, port, command order.
    wire logic [3:0] req = {CMD_REQ_IN, SLAVE_DMA_PORT_REQ_IN, INTERNAL_DMA_ENGINE_REQ_IN, CORE_REQ_IN};
    wire logic [3:0] gnt = {CMD_GRANT_OUT, SLAVE_DMA_PORT_GRANT_OUT, INTERNAL_DMA_ENGINE_GRANT_OUT, CORE_GRANT_OUT};
    // The two steps of one APB transfer.
    sequence s_setup;
        PSEL_IN && !PENABLE_IN;
    endsequence
    sequence s_access;
        PSEL_IN && PENABLE_IN && PREADY_OUT;
    endsequence
    a_grant_one_hot: assert property ($onehot0(gnt))
        else $error("more than one grant");
    a_grant_from_req: assert property ((gnt & ~$past(req)) == 4'h0)
        else $error("grant without request");
    a_grant_one_cycle: assert property ((gnt & $past(gnt)) == 4'h0)
        else $error("grant pulse too long");
    a_lone_core: assert property (CORE_REQ_IN && !CORE_GRANT_OUT && req[3:1] == 3'h0
        |=> CORE_GRANT_OUT) else $error("lone core not granted");
    a_lone_engine: assert property (INTERNAL_DMA_ENGINE_REQ_IN && !INTERNAL_DMA_ENGINE_GRANT_OUT &&
        !CORE_REQ_IN && !SLAVE_DMA_PORT_REQ_IN && !CMD_REQ_IN |=> INTERNAL_DMA_ENGINE_GRANT_OUT)
        else $error("lone engine not granted");
    a_idle_quiet: assert property (req == 4'h0 |=> gnt == 4'h0)
        else $error("grant while idle");
    a_apb_ready: assert property (s_setup |=> s_access)
        else $error("ready not one cycle after setup");
    a_ready_pulse: assert property (PREADY_OUT |=> !PREADY_OUT)
        else $error("ready longer than one cycle");
    a_err_ready: assert property (PSLVERR_OUT |-> PREADY_OUT)
        else $error("error without ready");
    a_src_by_write: assert property (!$stable(DMA_SRC_OUT) |-> $past(PSEL_IN && PENABLE_IN
        && PWRITE_IN && PADDR_IN == lba_pkg::ADDR_DMA_SRC)) else $error("source changed alone");
endmodule : lba_arbiter_chk

bind lba_arbiter lba_arbiter_chk lba_arbiter_chk_inst (.*);

/* verif/test_l2_bandwidth_arbiter.sv */
// Self-checking bench for the bandwidth arbiter with four requester models.
// Assumes the arbiter, its package, the models and the checker are compiled first.
module test_l2_bandwidth_arbiter;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, rst, psel, penable, pwrite, pready, pslverr;
    logic [31:0] paddr, pwdata, prdata, src, dst;
    logic [15:0] size;
    logic [3:0]  go, hold, master;
    wire  [3:0]  req, gnt;
    int          err_count, n_tests;
    lba_arbiter lba_arbiter_inst (.CORE_CLK_IN(clk), .RESET_IN(rst), .PSEL_IN(psel),
        .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
        .PSTRB_IN(4'hF), .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
        .CORE_REQ_IN(req[0]), .INTERNAL_DMA_ENGINE_REQ_IN(req[1]), .SLAVE_DMA_PORT_REQ_IN(req[2]),
        .SLAVE_DMA_PORT_MASTER_IN(master), .CMD_REQ_IN(req[3]), .CORE_GRANT_OUT(gnt[0]),
        .INTERNAL_DMA_ENGINE_GRANT_OUT(gnt[1]), .SLAVE_DMA_PORT_GRANT_OUT(gnt[2]), .CMD_GRANT_OUT(gnt[3]),
        .DMA_SRC_OUT(src), .DMA_DST_OUT(dst), .DMA_SIZE_OUT(size));
    // One requester model per class.
    for (genvar i = 0; i < 4; i++) begin : g_req
        lba_req_model lba_req_model_inst (.clk_in(clk), .rst_in(rst), .go_in(go[i]),
            .hold_in(hold[i]), .grant_in(gnt[i]), .req_out(req[i]));
    end
    // Free-running 125 MHz clock.
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic final_report;
        if (err_count == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : final_report
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // One APB transfer; the request stands until ready is sampled high.
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) err_count++;
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask : wr
    task automatic rd(input string what, input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        chk(what, exp, r);
    endtask : rd
    // Waits until every pending request has been served.
    task automatic wait_idle;
        int n;
        n = 0;
        while (req !== 4'h0 && n < 60) begin
            @(negedge clk);
            n++;
        end
        chk("requests served", 32'h0, {28'h0, req});
    endtask : wait_idle
    // Raises the requests in m together and checks which is granted first.
    task automatic race(input logic [3:0] m, input logic [3:0] first);
        int n;
        @(posedge clk);
        go <= m;
        @(posedge clk);
        go <= 4'h0;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (gnt === 4'h0 && n < 30);
        if (first !== 4'h0) chk("first grant", {28'h0, first}, {28'h0, gnt});
        wait_idle();
    endtask : race
    task automatic t_reset_regs;
        logic [31:0] r;
        logic        e;
        rd("core pri", lba_pkg::ADDR_CORE_PRI, 32'h0000_0001);
        rd("count", lba_pkg::ADDR_DMA_CNT, 32'h8000_0000);
        rd("master one", lba_pkg::ADDR_MST_PRI1, 32'h4444_4444);
        rd("master two", lba_pkg::ADDR_MST_PRI2, 32'h4444_4444);
        rd("threshold", lba_pkg::ADDR_THRESHOLD, 32'h0000_0010);
        rd("status", lba_pkg::ADDR_STATUS, 32'h0000_0000);
        apb(1'b0, 32'h0184_100C, 32'h0, r, e);
        chk("unmapped error", 32'h1, {31'h0, e});
    endtask : t_reset_regs
    task automatic t_dma_regs;
        wr(lba_pkg::ADDR_DMA_SRC, 32'h1234_5678);
        wr(lba_pkg::ADDR_DMA_DST, 32'h9ABC_DEF0);
        wr(lba_pkg::ADDR_DMA_CNT, 32'hA000_0040);
        @(negedge clk);
        chk("source", 32'h1234_5678, src);
        chk("destination", 32'h9ABC_DEF0, dst);
        chk("size", 32'h0000_0040, {16'h0, size});
        rd("count back", lba_pkg::ADDR_DMA_CNT, 32'hA000_0040);
    endtask : t_dma_regs
    task automatic t_priorities;
        wr(lba_pkg::ADDR_CORE_PRI, 32'h0000_0003);
        wr(lba_pkg::ADDR_DMA_CNT, 32'h2000_0040);
        race(4'h3, 4'h2);
        wr(lba_pkg::ADDR_CORE_PRI, 32'h0000_0001);
        race(4'h3, 4'h1);
        wr(lba_pkg::ADDR_MST_PRI2, 32'h4444_4404);
        master <= 4'h9;
        race(4'h5, 4'h4);
        wr(lba_pkg::ADDR_DMA_CNT, 32'hC000_0040);
        race(4'hA, 4'h2);
        wr(lba_pkg::ADDR_DMA_CNT, 32'h8000_0040);
        master <= 4'h0;
        race(4'h6, 4'h2);
    endtask : t_priorities
    // Core and port stream at level 1 and hold off the engine until it starves.
    task automatic t_starve;
        int n;
        wr(lba_pkg::ADDR_THRESHOLD, 32'h0);
        wr(lba_pkg::ADDR_MST_PRI1, 32'h4444_4441);
        @(posedge clk);
        hold <= 4'h5;
        go <= 4'h2;
        @(posedge clk);
        go <= 4'h0;
        n = 0;
        repeat (40) begin
            @(negedge clk);
            if (gnt[1] === 1'b1) n++;
        end
        chk("engine while blocked", 32'h0, 32'(n));
        wr(lba_pkg::ADDR_THRESHOLD, 32'h4);
        n = 0;
        repeat (30) begin
            @(negedge clk);
            if (gnt[1] === 1'b1) n++;
        end
        chk("engine starved grant", 32'h1, 32'(n));
        @(posedge clk);
        hold <= 4'h0;
        wait_idle();
    endtask : t_starve
    // Watchdog against a hang.
    initial begin
        repeat (5000) @(posedge clk);
        err_count++;
        final_report();
    end
    // Main sequence.
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        go = 4'h0;
        hold = 4'h0;
        master = 4'h0;
        err_count = 0;
        n_tests = 0;
        rst = 1'b1;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        t_reset_regs();
        t_dma_regs();
        t_priorities();
        t_starve();
        final_report();
    end
endmodule : test_l2_bandwidth_arbiter
